// ==== dv/test_ref_phase_acq_config.sv ====
`default_nettype none

// Compares one value and counts the comparison
`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH %s expected %h seen %h", name, exp, got); end end

// ***************************************************************
// Register bank bench over classic Wishbone
// ***************************************************************
module test_ref_phase_acq_config;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk_i;
	logic              rst_i;
	logic [11:2]       wb_adr_i;
	logic [31:0]       wb_dat_i;
	logic [3:0]        wb_sel_i;
	logic              wb_we_i;
	logic              wb_cyc_i;
	logic              wb_stb_i;
	logic [31:0]       wb_dat_o;
	logic              wb_ack_o;
	logic [10:0]       acq_enable_o;
	logic [10:0][7:0]  hold_limit_code_o;
	logic [10:0][36:0] hold_limit_cycles_o;
	int                n_mismatch;
	int                cmp_count;
	logic [31:0]       rd;
	logic [7:0]        exp_code;
	logic [7:0]        dec_code [4] = '{8'h00, 8'h20, 8'h40, 8'hff};
	logic [36:0]       dec_cyc  [4] = '{37'h3e8, 37'h2710, 37'h186a0, 37'h15aacee900};

	rpac_regs u_dut (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.wb_adr_i            (wb_adr_i),
		.wb_dat_i            (wb_dat_i),
		.wb_sel_i            (wb_sel_i),
		.wb_we_i             (wb_we_i),
		.wb_cyc_i            (wb_cyc_i),
		.wb_stb_i            (wb_stb_i),
		.wb_dat_o            (wb_dat_o),
		.wb_ack_o            (wb_ack_o),
		.acq_enable_o        (acq_enable_o),
		.hold_limit_code_o   (hold_limit_code_o),
		.hold_limit_cycles_o (hold_limit_cycles_o)
	);

	// Free running system clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ***************************************************************
	// Bus tasks
	// ***************************************************************
	// One classic cycle, held until ack is sampled, then one idle cycle
	task automatic wb_xfer(input logic we, input logic [9:0] idx, input logic [7:0] wd,
			input logic [3:0] sel, output logic [31:0] data);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= idx;
		wb_dat_i <= {24'h000000, wd};
		wb_sel_i <= sel;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		data = wb_dat_o;
		if (n >= 50) begin
			n_mismatch++;
			$display("MISMATCH ack expected 1 seen timeout");
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : wb_xfer

	// Read one register and compare the whole word
	task automatic wb_check(input logic [9:0] idx, input logic [31:0] exp);
		wb_xfer(1'b0, idx, 8'h00, 4'hf, rd);
		`CHK("read data", exp, rd)
	endtask : wb_check

	// Reset held for sixteen cycles, first request one edge after release
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask : do_reset

	// Register defaults at the ports and over the bus
	task automatic check_defaults();
		`CHK("enables", 11'h7ff, acq_enable_o)
		wb_check(rpac_pkg::IDX_ENABLE_LOW, 32'h000000ff);
		wb_check(rpac_pkg::IDX_ENABLE_HIGH, 32'h00000007);
		for (int n = 0; n < 11; n++) begin
			exp_code = (n < 8) ? 8'h1b : 8'h0a;
			wb_check(rpac_pkg::IDX_LIMIT[n], {24'h000000, exp_code});
			`CHK("limit code", exp_code, hold_limit_code_o[n])
		end
		`CHK("limit cycles", 37'h1b42, hold_limit_cycles_o[0])
		`CHK("limit cycles", 37'h806, hold_limit_cycles_o[8])
	endtask : check_defaults

	// Closing verdict
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	// Hang guard, well beyond the length of the sequence
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		test_done();
	end

	// ***************************************************************
	// Test sequence
	// ***************************************************************
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		{wb_adr_i, wb_dat_i, wb_sel_i} = '0;
		n_mismatch = 0;
		cmp_count = 0;
		@(posedge clk_i);
		do_reset();
		check_defaults();
		// Enable bits per input, reserved upper bits kept at their default zero
		wb_xfer(1'b1, rpac_pkg::IDX_ENABLE_LOW, 8'ha5, 4'h1, rd);
		wb_xfer(1'b1, rpac_pkg::IDX_ENABLE_HIGH, 8'h02, 4'h1, rd);
		`CHK("enables", 11'h2a5, acq_enable_o)
		wb_check(rpac_pkg::IDX_ENABLE_HIGH, 32'h00000002);
		// Lane zero disabled and unmapped places leave everything alone
		wb_xfer(1'b1, rpac_pkg::IDX_ENABLE_LOW, 8'h00, 4'he, rd);
		wb_xfer(1'b1, 10'h075, 8'hff, 4'h1, rd);
		wb_xfer(1'b1, 10'h067, 8'hff, 4'h1, rd);
		wb_check(10'h075, 32'h00000000);
		`CHK("enables", 11'h2a5, acq_enable_o)
		// Each input keeps its own limit code
		for (int n = 0; n < 11; n++) begin
			wb_xfer(1'b1, rpac_pkg::IDX_LIMIT[n], 8'h80 + 8'(n * 13), 4'h1, rd);
		end
		for (int n = 0; n < 11; n++) begin
			wb_check(rpac_pkg::IDX_LIMIT[n], {24'h000000, 8'h80 + 8'(n * 13)});
			`CHK("limit code", 8'h80 + 8'(n * 13), hold_limit_code_o[n])
		end
		// Decoded durations at the ends and on decade boundaries
		for (int k = 0; k < 4; k++) begin
			wb_xfer(1'b1, rpac_pkg::IDX_LIMIT[0], dec_code[k], 4'h1, rd);
			repeat (2) @(posedge clk_i);
			`CHK("limit cycles", dec_cyc[k], hold_limit_cycles_o[0])
		end
		// A second reset in mid run restores every default
		do_reset();
		check_defaults();
		test_done();
	end

endmodule : test_ref_phase_acq_config

`default_nettype wire

// ==== logic/rpac_limit_decode.sv ====
`default_nettype none

// ***************************************************************
// Limit code to duration in clock cycles
// ***************************************************************
module rpac_limit_decode (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic [7:0]                 code_i,
	output logic      [rpac_pkg::CYC_W-1:0] cycles_o
);

	logic [rpac_pkg::CYC_W-1:0] next_cycles;
	logic [rpac_pkg::STEP_W-1:0] step;
	logic [rpac_pkg::DEC_W-1:0]  decade;

	// Step picks the mantissa, decade picks the power of ten
	always_comb begin
		step        = code_i[rpac_pkg::STEP_W-1:0];
		decade      = code_i[7:rpac_pkg::STEP_W];
		next_cycles = rpac_pkg::CYC_W'(rpac_pkg::MANT[step])
			* rpac_pkg::CYC_W'(rpac_pkg::POW10[decade]);                             // Full width product
	end

	// Register the decoded duration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cycles_o <= '0;
		end else begin
			cycles_o <= next_cycles;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	shortest_limit_a : assert property (@(posedge clk_i) disable iff (rst_i)
		code_i == rpac_pkg::CODE_MIN |=> cycles_o == rpac_pkg::CYC_W'(rpac_pkg::LIMIT_MIN_CYC))
		else $error("Code zero did not decode to ten microseconds");
	longest_limit_a : assert property (@(posedge clk_i) disable iff (rst_i)
		code_i == rpac_pkg::CODE_MAX |=> cycles_o == rpac_pkg::CYC_MAX)
		else $error("Code all ones did not decode to the longest limit");
	one_ms_point_a : assert property (@(posedge clk_i) disable iff (rst_i)
		code_i == rpac_pkg::CODE_ONE_MS |=> cycles_o == rpac_pkg::CYC_ONE_MS)
		else $error("Code 0x40 did not decode to one millisecond");
	decade_step_a : assert property (@(posedge clk_i) disable iff (rst_i)
		(code_i < 8'he0) ##1 (code_i == $past(code_i) + 8'h20)
		|=> cycles_o == $past(cycles_o) * 37'h0a)
		else $error("Thirty-two code steps did not scale the limit tenfold");

endmodule : rpac_limit_decode

`default_nettype wire

// ==== logic/rpac_pkg.sv ====
`default_nettype none

// ***************************************************************
// Register map and limit coding constants
// ***************************************************************
package rpac_pkg;

	// ***************************************************************
	// Clock and bus
	// ***************************************************************
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          NUM_INPUTS    = 11;
	localparam int          ADR_W         = 10;   // Word address, byte address bits 11:2
	localparam int          DAT_W         = 32;
	localparam int          REG_W         = 8;
	localparam int          CYC_W         = 37;   // Holds the longest limit in clock cycles

	// ***************************************************************
	// Register indices, byte address is four times the index
	// ***************************************************************
	localparam logic [ADR_W-1:0] IDX_ENABLE_LOW  = 10'h068;
	localparam logic [ADR_W-1:0] IDX_ENABLE_HIGH = 10'h069;
	localparam logic [ADR_W-1:0] IDX_LIMIT [NUM_INPUTS] = '{
		10'h06a, 10'h06b, 10'h06c, 10'h06d, 10'h06e, 10'h06f,
		10'h070, 10'h071, 10'h072, 10'h073, 10'h074
	};

	// ***************************************************************
	// Fields and reset values
	// ***************************************************************
	localparam int               EN_LOW_W        = 8;    // Inputs zero to seven
	localparam int               EN_HIGH_W       = 3;    // Inputs eight to ten, bits 2:0
	localparam logic [7:0]       RST_ENABLE_LOW  = 8'hff;
	localparam logic [2:0]       RST_ENABLE_HIGH = 3'h7;
	localparam logic [REG_W-1:0] RST_LIMIT [NUM_INPUTS] = '{
		8'h1b, 8'h1b, 8'h1b, 8'h1b, 8'h1b, 8'h1b,
		8'h1b, 8'h1b, 8'h0a, 8'h0a, 8'h0a
	};

	// ***************************************************************
	// Logarithmic limit coding: 32 steps per decade from 10 us
	// ***************************************************************
	localparam int          LIMIT_MIN_US   = 10;
	localparam int          LIMIT_MIN_CYC  = LIMIT_MIN_US * 1000 / CLK_PERIOD_NS;
	localparam int          STEPS_PER_DEC  = 32;
	localparam int          STEP_W         = 5;    // Code bits 4:0 select the step
	localparam int          DEC_W          = 3;    // Code bits 7:5 select the decade
	localparam int          MANT_W         = 14;
	localparam int          POW_W          = 24;
	localparam logic [7:0]  CODE_MIN       = 8'h00;
	localparam logic [7:0]  CODE_ONE_MS    = 8'h40;
	localparam logic [7:0]  CODE_MAX       = 8'hff;
	localparam logic [CYC_W-1:0] CYC_ONE_MS = 37'h00000186a0;
	localparam logic [CYC_W-1:0] CYC_MAX    = 37'h15aacee900;  // 9306 * 10^7 cycles

	// Cycles of the first decade, 10 us times 10^(k/32), rounded
	localparam logic [MANT_W-1:0] MANT [STEPS_PER_DEC] = '{
		14'h03e8, 14'h0433, 14'h0483, 14'h04d9, 14'h0536, 14'h0599, 14'h0604, 14'h0677,
		14'h06f2, 14'h0777, 14'h0806, 14'h089f, 14'h0943, 14'h09f4, 14'h0ab2, 14'h0b7f,
		14'h0c5a, 14'h0d46, 14'h0e44, 14'h0f54, 14'h1079, 14'h11b4, 14'h1306, 14'h1471,
		14'h15f7, 14'h179b, 14'h195e, 14'h1b42, 14'h1d4b, 14'h1f7a, 14'h21d4, 14'h245a
	};

	// Scale of each decade
	localparam logic [POW_W-1:0] POW10 [8] = '{
		24'h000001, 24'h00000a, 24'h000064, 24'h0003e8,
		24'h002710, 24'h0186a0, 24'h0f4240, 24'h989680
	};

endpackage : rpac_pkg

`default_nettype wire

// ==== logic/rpac_regs.sv ====
// The Wishbone slave port is this design's own decision.
`default_nettype none

// ***************************************************************
// Phase acquisition enables and hold limits, Wishbone slave
// ***************************************************************
module rpac_regs (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic [11:2]                 wb_adr_i,
	input  wire logic [31:0]                 wb_dat_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic                        wb_we_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	output logic      [10:0]                 acq_enable_o,
	output logic      [10:0][7:0]            hold_limit_code_o,
	output logic      [10:0][36:0]           hold_limit_cycles_o
);

	// ***************************************************************
	// Address decode
	// ***************************************************************
	localparam logic [3:0] SLOT_NONE     = 4'hf;
	localparam logic [3:0] SLOT_EN_LOW   = 4'hb;
	localparam logic [3:0] SLOT_EN_HIGH  = 4'hc;

	// Map a word index to a limit slot 0..10, an enable slot or none
	function automatic logic [3:0] slot_of(input logic [rpac_pkg::ADR_W-1:0] adr);
		logic [3:0] s;
		s = SLOT_NONE;
		if (adr == rpac_pkg::IDX_ENABLE_LOW) begin
			s = SLOT_EN_LOW;
		end
		if (adr == rpac_pkg::IDX_ENABLE_HIGH) begin
			s = SLOT_EN_HIGH;
		end
		for (int n = 0; n < rpac_pkg::NUM_INPUTS; n++) begin
			if (adr == rpac_pkg::IDX_LIMIT[n]) begin
				s = 4'(n);
			end
		end
		return s;
	endfunction : slot_of

	logic [3:0] slot;
	logic       req;
	logic       commit;

	// Request decode, a write lands on the edge where ack is seen high
	always_comb begin
		slot   = slot_of(wb_adr_i);
		req    = wb_cyc_i & wb_stb_i;
		commit = req & wb_we_i & wb_ack_o & wb_sel_i[0];
	end

	// ***************************************************************
	// Bus answer
	// ***************************************************************
	logic        next_ack;
	logic [31:0] next_dat;

	// One wait state, ack drops the cycle after it was given
	always_comb begin
		next_ack = req & ~wb_ack_o;
		next_dat = '0;                                        // Unmapped reads return zero
		if (slot == SLOT_EN_LOW) begin
			next_dat[7:0] = acq_enable_o[7:0];
		end else if (slot == SLOT_EN_HIGH) begin
			next_dat[2:0] = acq_enable_o[10:8];
		end else if (slot != SLOT_NONE) begin
			next_dat[7:0] = hold_limit_code_o[slot];
		end
	end

	// Register ack and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// ***************************************************************
	// Configuration registers
	// ***************************************************************
	logic [10:0]      next_enable;
	logic [10:0][7:0] next_code;

	// Byte lane 0 carries every register; upper lanes are ignored
	always_comb begin
		next_enable = acq_enable_o;
		next_code   = hold_limit_code_o;
		if (commit && slot == SLOT_EN_LOW) begin
			next_enable[7:0] = wb_dat_i[7:0];
		end
		if (commit && slot == SLOT_EN_HIGH) begin
			next_enable[10:8] = wb_dat_i[2:0];
		end
		if (commit && slot < 4'(rpac_pkg::NUM_INPUTS)) begin
			next_code[slot] = wb_dat_i[7:0];
		end
	end

	// Store enables and codes, defaults on reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acq_enable_o <= {rpac_pkg::RST_ENABLE_HIGH, rpac_pkg::RST_ENABLE_LOW};
			for (int n = 0; n < rpac_pkg::NUM_INPUTS; n++) begin
				hold_limit_code_o[n] <= rpac_pkg::RST_LIMIT[n];
			end
		end else begin
			acq_enable_o      <= next_enable;
			hold_limit_code_o <= next_code;
		end
	end

	// ***************************************************************
	// Limit decoders, one per input, feed the hold datapaths
	// ***************************************************************
	for (genvar g = 0; g < rpac_pkg::NUM_INPUTS; g++) begin : g_dec
		rpac_limit_decode u_dec (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.code_i   (hold_limit_code_o[g]),
			.cycles_o (hold_limit_cycles_o[g])
		);
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	sequence bus_req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence wr_low_s;
		commit && slot == SLOT_EN_LOW;
	endsequence

	sequence wr_high_s;
		commit && slot == SLOT_EN_HIGH;
	endsequence

	sequence rd_high_s;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && slot == SLOT_EN_HIGH;
	endsequence

	ack_answer_a : assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req_s |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Ack did not follow a request for exactly one cycle");
	enable_low_a : assert property (@(posedge clk_i) disable iff (rst_i)
		wr_low_s |=> acq_enable_o[7:0] == $past(wb_dat_i[7:0]))
		else $error("Low enable write did not reach the acquisition enables");
	enable_high_a : assert property (@(posedge clk_i) disable iff (rst_i)
		wr_high_s |=> acq_enable_o[10:8] == $past(wb_dat_i[2:0]))
		else $error("High enable write did not reach inputs eight to ten");
	reserved_zero_a : assert property (@(posedge clk_i) disable iff (rst_i)
		rd_high_s |=> wb_dat_o[31:3] == '0 && wb_dat_o[2:0] == $past(acq_enable_o[10:8]))
		else $error("High enable read returned reserved bits or wrong enables");
	limit_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
		commit && slot == 4'h3 |=> hold_limit_code_o[3] == $past(wb_dat_i[7:0])
		&& hold_limit_code_o[2] == $past(hold_limit_code_o[2]))
		else $error("Limit write did not land in its own input only");
	enable_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
		!commit |=> acq_enable_o == $past(acq_enable_o))
		else $error("Enables changed without a committed write");
	reset_default_a : assert property (@(posedge clk_i)
		$past(rst_i) |-> acq_enable_o == 11'h7ff && hold_limit_code_o[8] == 8'h0a)
		else $error("Enables or limits not at default after reset");
	decode_path_a : assert property (@(posedge clk_i) disable iff (rst_i)
		hold_limit_code_o[0] == 8'h00 ##1 hold_limit_code_o[0] == 8'h00
		|-> hold_limit_cycles_o[0] == 37'h00000003e8)
		else $error("Input zero code 0x00 did not give ten microseconds");
	unmapped_read_a : assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o && slot == SLOT_NONE |=> wb_dat_o == '0)
		else $error("Unmapped read did not return zero");
	limit_read_a : assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o && slot == 4'h9
		|=> wb_dat_o == {24'h000000, $past(hold_limit_code_o[9])})
		else $error("Limit read did not return the stored code of input nine");

endmodule : rpac_regs

`default_nettype wire
